/* hdl/eq_search_pkg.sv */
// Constants for the adaptive equalizer gain search controller
package eq_search_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_ERROR_SELECT = 8'h42;
    localparam logic [7:0] ADDR_SEARCH_CTL = 8'hD2;
    localparam logic [7:0] ADDR_SEARCH_STATUS = 8'hD3;
    localparam logic [7:0] ADDR_GAIN_LIMITS = 8'hD5;

    // Reset values
    localparam logic [7:0] RST_ERROR_SELECT = 8'h4F;
    localparam logic [7:0] RST_SEARCH_CTL = 8'h60;
    localparam logic [7:0] RST_GAIN_LIMITS = 8'hF0;

    // Error select fields
    localparam int ERRSEL_CLK_BIT = 0;
    localparam int ERRSEL_ENC_BIT = 1;
    localparam int ERRSEL_PAR_BIT = 2;
    localparam int ERRSEL_CHECK_BIT = 3;
    localparam int ERRSEL_THR_LSB = 4;
    localparam int ERRSEL_THR_MSB = 7;

    // Search control fields
    localparam int CTL_FLOOR_EN_BIT = 2;
    localparam int CTL_RESTART_BIT = 3;
    localparam int CTL_FIRST_DIS_BIT = 4;
    localparam int CTL_DWELL_LSB = 5;
    localparam int CTL_DWELL_MSB = 7;

    // Gain limit fields
    localparam int LIM_FLOOR_LSB = 0;
    localparam int LIM_FLOOR_MSB = 3;
    localparam int LIM_CEIL_LSB = 4;
    localparam int LIM_CEIL_MSB = 7;

    // Status fields
    localparam int STS_GAIN_LSB = 0;
    localparam int STS_GAIN_MSB = 3;
    localparam int STS_HOLD_BIT = 4;
    localparam int STS_FIRST_DONE_BIT = 5;

    // Widths and fixed values
    localparam int GAIN_W = 4;
    localparam int TIMER_W = 24;
    localparam int ERRCNT_W = 8;
    localparam logic [GAIN_W-1:0] GAIN_ZERO = 4'h0;
    localparam logic [GAIN_W-1:0] GAIN_ONE = 4'h1;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h00_0001;
    localparam logic [ERRCNT_W-1:0] ERRCNT_MAX = 8'hFF;
    localparam logic [ERRCNT_W-1:0] ERRCNT_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Dwell timing: field code 3 selects the default time
    localparam real CLK_MHZ = 25.0;
    localparam real DWELL_DEFAULT_MS = 2.62;
    localparam int DWELL_DEFAULT_CYC = int'(DWELL_DEFAULT_MS * 1000.0 * CLK_MHZ);
    localparam int DWELL_DEFAULT_SHIFT = 3;

    typedef enum logic {
        S_DWELL,
        S_HOLD
    } search_state_e;

endpackage

/* hdl/adaptive_eq_search_control.sv */
// Adaptive equalizer gain search controller for one receive port
`timescale 1ns/1ns
module adaptive_eq_search_control #(
    parameter int DWELL_CYCLES = eq_search_pkg::DWELL_DEFAULT_CYC
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic DIGITAL_SOFT_RESET,
    input wire logic CDR_LOCK,
    input wire logic ERR_CLK_RECOVERY,
    input wire logic ERR_ENCODING,
    input wire logic ERR_PARITY,
    output logic [eq_search_pkg::GAIN_W-1:0] EQ_GAIN,
    output logic EQ_HOLD
);

    logic [7:0] error_select_r;
    logic [7:0] search_ctl_r;
    logic [7:0] gain_limits_r;
    logic [7:0] rdata_r;
    logic [7:0] status_byte;
    logic [eq_search_pkg::GAIN_W-1:0] gain_r;
    logic [eq_search_pkg::TIMER_W-1:0] timer_r;
    logic [eq_search_pkg::ERRCNT_W-1:0] errcnt_r;
    logic [eq_search_pkg::ERRCNT_W-1:0] errcnt_nxt;
    logic first_done_r;
    eq_search_pkg::search_state_e state_r;

    logic restart_req;
    logic floor_en;
    logic first_arm;
    logic err_check_en;
    logic err_seen;
    logic err_trip;
    logic at_dwell_end;
    logic at_half_end;
    logic win_clear;
    logic [eq_search_pkg::GAIN_W-1:0] gain_floor;
    logic [eq_search_pkg::GAIN_W-1:0] gain_ceiling;
    logic [eq_search_pkg::GAIN_W-1:0] gain_min;
    logic [eq_search_pkg::GAIN_W-1:0] gain_next;
    logic [eq_search_pkg::GAIN_W-1:0] err_threshold;
    logic [2:0] dwell_sel;
    logic [31:0] dwell_wide;
    logic [eq_search_pkg::TIMER_W-1:0] dwell_len;
    logic [eq_search_pkg::TIMER_W-1:0] dwell_end;
    logic [eq_search_pkg::TIMER_W-1:0] half_end;
    logic [eq_search_pkg::ERRCNT_W-1:0] threshold_wide;
    logic ctl_wr;
    logic restart_floor_en;
    logic [eq_search_pkg::GAIN_W-1:0] restart_gain;

    // Field decode
    assign floor_en = search_ctl_r[eq_search_pkg::CTL_FLOOR_EN_BIT];
    assign first_arm = !first_done_r && !search_ctl_r[eq_search_pkg::CTL_FIRST_DIS_BIT];
    assign dwell_sel = search_ctl_r[eq_search_pkg::CTL_DWELL_MSB:eq_search_pkg::CTL_DWELL_LSB];
    assign gain_floor = gain_limits_r[eq_search_pkg::LIM_FLOOR_MSB:eq_search_pkg::LIM_FLOOR_LSB];
    assign gain_ceiling = gain_limits_r[eq_search_pkg::LIM_CEIL_MSB:eq_search_pkg::LIM_CEIL_LSB];
    assign err_check_en = error_select_r[eq_search_pkg::ERRSEL_CHECK_BIT];
    assign err_threshold =
        error_select_r[eq_search_pkg::ERRSEL_THR_MSB:eq_search_pkg::ERRSEL_THR_LSB];

    // Restart on bit write or soft reset; restart bit itself is not stored
    assign restart_req = DIGITAL_SOFT_RESET
        | (REG_WR && REG_ADDR == eq_search_pkg::ADDR_SEARCH_CTL
           && REG_WDATA[eq_search_pkg::CTL_RESTART_BIT]);

    // Lowest code of the window
    assign gain_min = floor_en ? gain_floor : eq_search_pkg::GAIN_ZERO;

    // A control write that also restarts must use the floor enable it carries
    assign ctl_wr = REG_WR && REG_ADDR == eq_search_pkg::ADDR_SEARCH_CTL;
    assign restart_floor_en = ctl_wr ? REG_WDATA[eq_search_pkg::CTL_FLOOR_EN_BIT] : floor_en;
    assign restart_gain = restart_floor_en ? gain_floor : eq_search_pkg::GAIN_ZERO;

    // Next code, wrapping at the ceiling; >= also catches a code left above it
    assign gain_next = (gain_r >= gain_ceiling) ? gain_min
                                                : gain_r + eq_search_pkg::GAIN_ONE;

    // Dwell length scales by powers of two around the default code
    assign dwell_wide = (32'(DWELL_CYCLES) << dwell_sel) >> eq_search_pkg::DWELL_DEFAULT_SHIFT;
    assign dwell_len = dwell_wide[eq_search_pkg::TIMER_W-1:0];
    assign dwell_end = dwell_len - eq_search_pkg::TIMER_ONE;
    assign half_end = (dwell_len >> 1) - eq_search_pkg::TIMER_ONE;
    assign at_dwell_end = (timer_r == dwell_end);
    assign at_half_end = (timer_r == half_end);

    // Selected error sources
    assign err_seen = (ERR_CLK_RECOVERY && error_select_r[eq_search_pkg::ERRSEL_CLK_BIT])
        || (ERR_ENCODING && error_select_r[eq_search_pkg::ERRSEL_ENC_BIT])
        || (ERR_PARITY && error_select_r[eq_search_pkg::ERRSEL_PAR_BIT]);
    assign threshold_wide =
        {{(eq_search_pkg::ERRCNT_W-eq_search_pkg::GAIN_W){1'b0}}, err_threshold};
    assign err_trip = err_check_en && at_half_end
        && (errcnt_r > threshold_wide);

    // Window closes at each half or full dwell, on restart, or on lock loss while holding
    assign win_clear = restart_req || at_half_end || at_dwell_end
        || (state_r == eq_search_pkg::S_HOLD && !CDR_LOCK);

    // Register writes
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            error_select_r <= eq_search_pkg::RST_ERROR_SELECT;
            search_ctl_r <= eq_search_pkg::RST_SEARCH_CTL;
            gain_limits_r <= eq_search_pkg::RST_GAIN_LIMITS;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                eq_search_pkg::ADDR_ERROR_SELECT: error_select_r <= REG_WDATA;
                eq_search_pkg::ADDR_SEARCH_CTL:
                begin
                    // Restart bit is a strobe, reads back as zero
                    search_ctl_r <= REG_WDATA;
                    search_ctl_r[eq_search_pkg::CTL_RESTART_BIT] <= 1'b0;
                end
                eq_search_pkg::ADDR_GAIN_LIMITS: gain_limits_r <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // Status byte
    always_comb
    begin
        status_byte = eq_search_pkg::BYTE_ZERO;
        status_byte[eq_search_pkg::STS_GAIN_MSB:eq_search_pkg::STS_GAIN_LSB] = gain_r;
        status_byte[eq_search_pkg::STS_HOLD_BIT] = (state_r == eq_search_pkg::S_HOLD);
        status_byte[eq_search_pkg::STS_FIRST_DONE_BIT] = first_done_r;
    end

    // Read data, captured one cycle after the read strobe
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_r <= eq_search_pkg::BYTE_ZERO;
        end
        else if (REG_RD)
        begin
            case (REG_ADDR)
                eq_search_pkg::ADDR_ERROR_SELECT: rdata_r <= error_select_r;
                eq_search_pkg::ADDR_SEARCH_CTL: rdata_r <= search_ctl_r;
                eq_search_pkg::ADDR_SEARCH_STATUS: rdata_r <= status_byte;
                eq_search_pkg::ADDR_GAIN_LIMITS: rdata_r <= gain_limits_r;
                default: rdata_r <= eq_search_pkg::BYTE_ZERO;
            endcase
        end
    end

    // Error accumulator, saturating so a burst cannot wrap under threshold
    always_comb
    begin
        errcnt_nxt = errcnt_r;
        if (win_clear)
        begin
            errcnt_nxt = '0;
        end
        else if (err_seen && errcnt_r != eq_search_pkg::ERRCNT_MAX)
        begin
            errcnt_nxt = errcnt_r + eq_search_pkg::ERRCNT_ONE;
        end
    end

    // Accumulator register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            errcnt_r <= '0;
        end
        else
        begin
            errcnt_r <= errcnt_nxt;
        end
    end

    // Search sequencer; starts dwelling from reset with no command
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_r <= eq_search_pkg::S_DWELL;
            gain_r <= eq_search_pkg::GAIN_ZERO;
            timer_r <= '0;
        end
        // Restart outranks every search step, in either state
        else if (restart_req)
        begin
            state_r <= eq_search_pkg::S_DWELL;
            gain_r <= restart_gain;
            timer_r <= '0;
        end
        else
        begin
            case (state_r)
                eq_search_pkg::S_DWELL:
                begin
                    if (err_trip)
                    begin
                        gain_r <= gain_next;
                        timer_r <= '0;
                    end
                    else if (at_dwell_end)
                    begin
                        timer_r <= '0;
                        if (CDR_LOCK && first_arm)
                        begin
                            // One restart from a known start point
                            gain_r <= gain_min;
                        end
                        else if (CDR_LOCK)
                        begin
                            state_r <= eq_search_pkg::S_HOLD;
                        end
                        else
                        begin
                            gain_r <= gain_next;
                        end
                    end
                    else
                    begin
                        timer_r <= timer_r + eq_search_pkg::TIMER_ONE;
                    end
                end
                eq_search_pkg::S_HOLD:
                begin
                    if (!CDR_LOCK)
                    begin
                        state_r <= eq_search_pkg::S_DWELL;
                        gain_r <= gain_next;
                        timer_r <= '0;
                    end
                    else if (err_trip)
                    begin
                        // Locked but noisy: try more gain
                        state_r <= eq_search_pkg::S_DWELL;
                        gain_r <= gain_next;
                        timer_r <= '0;
                    end
                    else if (at_half_end)
                    begin
                        timer_r <= '0;
                    end
                    else
                    begin
                        timer_r <= timer_r + eq_search_pkg::TIMER_ONE;
                    end
                end
                default:
                begin
                    state_r <= eq_search_pkg::S_DWELL;
                    timer_r <= '0;
                end
            endcase
        end
    end

    // First-lock restart is spent once; only a power-on reset re-arms it
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            first_done_r <= 1'b0;
        end
        else if (!restart_req && state_r == eq_search_pkg::S_DWELL && !err_trip
            && at_dwell_end && CDR_LOCK && first_arm)
        begin
            first_done_r <= 1'b1;
        end
    end

    // Outputs straight from registers; hold flag decoded from the state
    assign REG_RDATA = rdata_r;
    assign EQ_GAIN = gain_r;
    assign EQ_HOLD = (state_r == eq_search_pkg::S_HOLD);

endmodule

/* tb/eq_search_props.sv */
// Port-level checks for the equalizer gain search controller
`timescale 1ns/1ns
module eq_search_props #(
    parameter int DWELL_CYCLES = 64
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic DIGITAL_SOFT_RESET,
    input wire logic CDR_LOCK,
    input wire logic ERR_CLK_RECOVERY,
    input wire logic ERR_ENCODING,
    input wire logic ERR_PARITY,
    input wire logic [3:0] EQ_GAIN,
    input wire logic EQ_HOLD
);
    // Dwell figures assume the reset dwell select, where L equals DWELL_CYCLES
    localparam int HALF = DWELL_CYCLES / 2;
    logic [3:0] ceil_r;
    logic [3:0] floor_r;
    logic floor_en_r;
    logic [3:0] gain_q_r;
    logic [23:0] cnt_r;
    logic wr_ctl;
    logic restart_w;
    logic [3:0] min_w;
    logic [3:0] nxt_w;
    // Restart sources and the next code the search should take
    assign wr_ctl = REG_WR && REG_ADDR == eq_search_pkg::ADDR_SEARCH_CTL;
    assign restart_w = (wr_ctl && REG_WDATA[3]) || DIGITAL_SOFT_RESET;
    assign min_w = floor_en_r ? floor_r : 4'h0;
    assign nxt_w = (EQ_GAIN >= ceil_r) ? min_w : EQ_GAIN + 4'h1;
    // Shadow of the limit fields, taken from the write strobes
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            {ceil_r, floor_r} <= 8'hF0;
            floor_en_r <= 1'b0;
        end
        else if (REG_WR && REG_ADDR == eq_search_pkg::ADDR_GAIN_LIMITS)
            {ceil_r, floor_r} <= REG_WDATA;
        else if (wr_ctl)
            floor_en_r <= REG_WDATA[2];
    end
    // Cycles spent at the present code; a change is seen one edge late
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            gain_q_r <= 4'h0;
            cnt_r <= 24'h00_0000;
        end
        else
        begin
            gain_q_r <= EQ_GAIN;
            if (restart_w)
                cnt_r <= 24'h00_0000;
            else if (EQ_GAIN != gain_q_r)
                cnt_r <= 24'h00_0001;
            else
                cnt_r <= cnt_r + 24'h00_0001;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_hold_stable: assert property (EQ_HOLD && $past(EQ_HOLD) |-> EQ_GAIN == $past(EQ_GAIN))
        else $error("gain moved while holding");
    a_loss_advance: assert property (EQ_HOLD && !CDR_LOCK && !restart_w && !REG_WR
        |=> !EQ_HOLD && EQ_GAIN == $past(nxt_w)) else $error("no advance on lock loss");
    a_restart_min: assert property (wr_ctl && REG_WDATA[3] |=> EQ_GAIN == min_w)
        else $error("restart not at minimum");
    a_soft_min: assert property (DIGITAL_SOFT_RESET && !REG_WR |=> EQ_GAIN == min_w && !EQ_HOLD)
        else $error("soft reset not at minimum");
    a_gain_ceiling: assert property (EQ_GAIN != gain_q_r |-> EQ_GAIN <= ceil_r || EQ_GAIN == min_w)
        else $error("gain above ceiling");
    a_dwell_full: assert property ($rose(EQ_HOLD) |-> cnt_r >= DWELL_CYCLES)
        else $error("hold before dwell end");
    a_no_early_step: assert property (EQ_GAIN != gain_q_r && !$past(restart_w)
        && !$past(EQ_HOLD) |-> cnt_r >= HALF) else $error("code stepped too early");
    a_status_read: assert property (REG_RD && REG_ADDR == eq_search_pkg::ADDR_SEARCH_STATUS
        |=> REG_RDATA[4:0] == {$past(EQ_HOLD), $past(EQ_GAIN)}) else $error("bad status read");
    c_lock_found: cover property ($rose(EQ_HOLD));
    c_lock_lost: cover property (EQ_HOLD && !CDR_LOCK);
    c_soft_reset: cover property (DIGITAL_SOFT_RESET);
endmodule
bind adaptive_eq_search_control eq_search_props #(.DWELL_CYCLES(DWELL_CYCLES)) u_props (
    .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .DIGITAL_SOFT_RESET(DIGITAL_SOFT_RESET), .CDR_LOCK(CDR_LOCK),
    .ERR_CLK_RECOVERY(ERR_CLK_RECOVERY), .ERR_ENCODING(ERR_ENCODING),
    .ERR_PARITY(ERR_PARITY), .EQ_GAIN(EQ_GAIN), .EQ_HOLD(EQ_HOLD));

/* tb/link_partner_model.sv */
// Remote serializer model: lock and error flags seen through the equalizer
`timescale 1ns/1ns
module link_partner_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] gain,
    input wire logic [3:0] lock_lo,
    input wire logic [3:0] lock_hi,
    input wire logic [2:0] err_on,
    output logic lock,
    output logic [2:0] err
);
    // Only a gain inside the eye window recovers the clock, one cycle late
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock <= 1'b0;
            err <= 3'b000;
        end
        else
        begin
            lock <= (gain >= lock_lo) && (gain <= lock_hi);
            err <= err_on;
        end
    end
endmodule

/* tb/test_adaptive_eq_search_control.sv */
// Self-checking bench for the equalizer gain search controller
`timescale 1ns/1ns
module test_adaptive_eq_search_control;
    // Short dwell keeps the run brief
    localparam int DW = 64;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_RDATA;
    logic DIGITAL_SOFT_RESET = 1'b0;
    logic CDR_LOCK;
    logic [2:0] err;
    logic [3:0] EQ_GAIN;
    logic EQ_HOLD;
    logic [3:0] lo = 4'hF;
    logic [3:0] hi = 4'h0;
    logic [2:0] err_on = 3'b000;
    logic [3:0] gmax;
    logic [3:0] gmin;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    adaptive_eq_search_control #(.DWELL_CYCLES(DW)) dut (.CLK(CLK), .ARST_N(ARST_N),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .DIGITAL_SOFT_RESET(DIGITAL_SOFT_RESET), .CDR_LOCK(CDR_LOCK),
        .ERR_CLK_RECOVERY(err[0]), .ERR_ENCODING(err[1]), .ERR_PARITY(err[2]),
        .EQ_GAIN(EQ_GAIN), .EQ_HOLD(EQ_HOLD));
    link_partner_model partner (.clk(CLK), .arst_n(ARST_N), .gain(EQ_GAIN), .lock_lo(lo),
        .lock_hi(hi), .err_on(err_on), .lock(CDR_LOCK), .err(err));
    initial
    begin
        forever #20 CLK = ~CLK;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles the sequence needs
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            $display("[FAIL] %0t run hung", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Register port: one-cycle strobes, read data the cycle after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA, exp);
    endtask
    // Bounded wait for the search to settle, then gain extremes over a span
    task automatic wait_hold(input int n);
        for (int i = 0; i < n && EQ_HOLD !== 1'b1; i++)
        begin
            @(posedge CLK);
            #1;
        end
        chk({7'h00, EQ_HOLD}, 8'h01);
    endtask
    task automatic scan(input int n);
        gmax = 4'h0;
        gmin = 4'hF;
        repeat (n)
        begin
            @(posedge CLK);
            #1;
            gmax = (EQ_GAIN > gmax) ? EQ_GAIN : gmax;
            gmin = (EQ_GAIN < gmin) ? EQ_GAIN : gmin;
        end
    endtask
    initial
    begin
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(8'h42, 8'h4F);
        rd(8'hD2, 8'h60);
        rd(8'hD5, 8'hF0);
        lo = 4'h5;
        hi = 4'h5;
        wait_hold(2000);
        rd(8'hD3, 8'h35);
        scan(300);
        chk({gmax, gmin}, 8'h55);
        lo = 4'h7;
        hi = 4'h7;
        scan(8);
        wait_hold(400);
        chk({4'h0, EQ_GAIN}, 8'h07);
        wr(8'hD5, 8'h93);
        lo = 4'hC;
        hi = 4'hC;
        scan(1500);
        chk({gmax, gmin}, 8'h90);
        wr(8'hD2, 8'h6C);
        chk({4'h0, EQ_GAIN}, 8'h03);
        scan(1500);
        chk({gmax, gmin}, 8'h93);
        wr(8'hD2, 8'h6C);
        scan(70);
        @(posedge CLK);
        DIGITAL_SOFT_RESET <= 1'b1;
        @(posedge CLK);
        DIGITAL_SOFT_RESET <= 1'b0;
        #1;
        chk({gmax, EQ_GAIN}, 8'h43);
        lo = 4'h0;
        hi = 4'hF;
        // Each error source alone trips the half-window count despite lock
        for (int i = 0; i < 3; i++)
        begin
            err_on = 3'b001 << i;
            wr(8'h42, 8'h48 | (8'h01 << i));
            wr(8'hD2, 8'h6C);
            scan(40);
            chk({gmax, gmin}, 8'h43);
        end
        err_on = 3'b111;
        wr(8'h42, 8'h47);
        wr(8'hD2, 8'h6C);
        rd(8'hD2, 8'h64);
        scan(100);
        chk({EQ_HOLD, 3'h0, gmax}, 8'h83);
        finish_test();
    end
endmodule
